//--- core_irq_defs.svh
`ifndef CORE_IRQ_DEFS_SVH
`define CORE_IRQ_DEFS_SVH
`define ADDR_INTERRUPT_CONTROL 8'h0b
`define ADDR_PERIPHERAL_IRQ_FLAGS 8'h0c
`define ADDR_PERIPHERAL_IRQ_ENABLES 8'h8c
`define ADDR_RESET_CAUSE_STATUS 8'h8e
`define ADDR_PROGRAM_COUNTER_LOW 8'h02
`define ADDR_COUNTER_UPPER_LATCH 8'h0a
`define BIT_GLOBAL_EN 7
`define BIT_BIT6_EN 6
`define BIT_TIMER_EN 5
`define BIT_EXT_EN 4
`define BIT_PORT_EN 3
`define BIT_TIMER_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_PORT_FLAG 0
`define BIT_CONV_FLAG 6
`define BIT_MIRROR 7
`define BIT_PARITY 2
`define BIT_POWERON 1
`define BIT_BROWNOUT 0
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_PERIPHERAL_ENABLES 8'h00
`define RST_STACK_PTR 3'h0
`endif

//--- core_irq_pkg.sv
package core_irq_pkg;
	typedef enum logic [3:0] {
		PC_HOLD = 4'h1,
		PC_STEP = 4'h2,
		PC_JUMP = 4'h4,
		PC_RET = 4'h8
	} pc_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_ACT = 2'h2
	} stack_state_t;
endpackage

//--- return_stack.sv
`timescale 1ns/100ps
`include "core_irq_defs.svh"
module return_stack #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 13
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [WIDTH-1:0] push_data_in,
	output logic [WIDTH-1:0] top_out
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [PW-1:0] ptr;
		logic [DEPTH-1:0][WIDTH-1:0] mem;
	} stack_st_t;
	stack_st_t s_q, s_d;
	// pointer wraps by natural overflow, so nothing flags overflow
	always_comb begin
		s_d = s_q;
		if (push_in) begin
			s_d.mem[s_q.ptr] = push_data_in;
			s_d.ptr = s_q.ptr + PW'(1);
		end else if (pop_in) begin
			s_d.ptr = s_q.ptr - PW'(1);
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_q.ptr <= '0;
			s_q.mem <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign top_out = s_q.mem[s_q.ptr - PW'(1)];
endmodule

//--- core_interrupt_pc_stack_ctrl.sv
`timescale 1ns/100ps
`include "core_irq_defs.svh"
module core_interrupt_pc_stack_ctrl #(
	parameter bit GATED_VARIANT = 1'b1,
	parameter bit PARITY_VARIANT = 1'b1,
	parameter int STACK_DEPTH = 8
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic POWER_ON_RESET_IN,
	input wire logic BROWNOUT_RESET_IN,
	input wire logic PARITY_RESET_IN,
	input wire logic PARITY_CFG_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	input wire logic TIMER_OVF_IN,
	input wire logic EXT_EDGE_IN,
	input wire logic PORT_CHANGE_IN,
	input wire logic CONV_DONE_IN,
	input wire logic STEP_IN,
	input wire logic JUMP_IN,
	input wire logic CALL_IN,
	input wire logic IRQ_BRANCH_IN,
	input wire logic RETURN_IN,
	input wire logic [10:0] TARGET_IN,
	input wire logic [12:0] IRQ_VECTOR_IN,
	output logic [12:0] PC_OUT,
	output logic IRQ_REQ_OUT
);
	typedef struct packed {
		logic [7:0] interrupt_control;
		logic conv_flag;
		logic conv_en;
		logic parity_st;
		logic poweron_st;
		logic brownout_st;
		logic [4:0] latch;
		logic [12:0] pc;
		logic [7:0] rdata;
	} st_t;
	st_t q, d;
	logic [12:0] stack_top;
	logic push;
	logic pop;
	logic wr_ic;
	logic wr_pir;
	logic [12:0] ret_pc;
	core_irq_pkg::pc_op_t op;

	assign push = CALL_IN | IRQ_BRANCH_IN;
	assign pop = RETURN_IN & ~push;
	assign ret_pc = push ? (PC_OUT + 13'h1) : 13'h0;
	assign wr_ic = WR_IN && ADDR_IN == `ADDR_INTERRUPT_CONTROL;
	assign wr_pir = WR_IN && ADDR_IN == `ADDR_PERIPHERAL_IRQ_FLAGS;

	return_stack #(.DEPTH(STACK_DEPTH), .WIDTH(13)) u_stack (
		.clk_in(CLK_SYS_IN),
		.rst_in(RST_IN),
		.push_in(push),
		.pop_in(pop),
		.push_data_in(ret_pc),
		.top_out(stack_top)
	);

	always_comb begin
		if (pop) op = core_irq_pkg::PC_RET;
		else if (JUMP_IN || push) op = core_irq_pkg::PC_JUMP;
		else if (STEP_IN) op = core_irq_pkg::PC_STEP;
		else op = core_irq_pkg::PC_HOLD;
	end

	always_comb begin
		d = q;
		// register writes first, so a hardware event in the same cycle wins
		if (wr_ic) d.interrupt_control = WDATA_IN;
		if (wr_pir) d.conv_flag = WDATA_IN[`BIT_CONV_FLAG];
		if (WR_IN && ADDR_IN == `ADDR_PERIPHERAL_IRQ_ENABLES)
			d.conv_en = WDATA_IN[`BIT_BIT6_EN];
		if (WR_IN && ADDR_IN == `ADDR_RESET_CAUSE_STATUS) begin
			d.parity_st = WDATA_IN[`BIT_PARITY];
			d.poweron_st = WDATA_IN[`BIT_POWERON];
			d.brownout_st = WDATA_IN[`BIT_BROWNOUT];
		end
		if (WR_IN && ADDR_IN == `ADDR_COUNTER_UPPER_LATCH) d.latch = WDATA_IN[4:0];
		if (TIMER_OVF_IN) d.interrupt_control[`BIT_TIMER_FLAG] = 1'b1;
		if (EXT_EDGE_IN) d.interrupt_control[`BIT_EXT_FLAG] = 1'b1;
		if (PORT_CHANGE_IN) d.interrupt_control[`BIT_PORT_FLAG] = 1'b1;
		if (CONV_DONE_IN) d.conv_flag = 1'b1;
		unique case (op)
			core_irq_pkg::PC_RET: d.pc = stack_top;
			core_irq_pkg::PC_JUMP: begin
				if (IRQ_BRANCH_IN) d.pc = IRQ_VECTOR_IN;
				else d.pc = {q.latch[4:3], TARGET_IN};
			end
			core_irq_pkg::PC_STEP: d.pc = q.pc + 13'h1;
			core_irq_pkg::PC_HOLD: d.pc = q.pc;
		endcase
		if (WR_IN && ADDR_IN == `ADDR_PROGRAM_COUNTER_LOW)
			d.pc = {q.latch, WDATA_IN};
		d.rdata = 8'h00;
		if (RD_IN) begin
			unique case (ADDR_IN)
				`ADDR_INTERRUPT_CONTROL: d.rdata = q.interrupt_control;
				`ADDR_PERIPHERAL_IRQ_FLAGS: d.rdata = {1'b0, q.conv_flag, 6'h00};
				`ADDR_PERIPHERAL_IRQ_ENABLES: d.rdata = {1'b0, q.conv_en, 6'h00};
				`ADDR_RESET_CAUSE_STATUS: d.rdata = {PARITY_VARIANT & PARITY_CFG_IN,
					4'h0, PARITY_VARIANT ? q.parity_st : 1'b0, q.poweron_st, q.brownout_st};
				`ADDR_PROGRAM_COUNTER_LOW: d.rdata = q.pc[7:0];
				`ADDR_COUNTER_UPPER_LATCH: d.rdata = {3'h0, q.latch};
				default: d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			q.interrupt_control <= `RST_INTERRUPT_CONTROL;
			q.conv_flag <= 1'b0;
			q.conv_en <= 1'b0;
			q.latch <= 5'h00;
			q.pc <= 13'h0000;
			q.rdata <= 8'h00;
			// cause bits keep value unless their own reset kind is flagged; power-on also sets parity_st when no parity reset is flagged
			if (POWER_ON_RESET_IN) q.poweron_st <= 1'b0;
			if (BROWNOUT_RESET_IN) q.brownout_st <= 1'b0;
			if (PARITY_RESET_IN) q.parity_st <= 1'b0;
			else if (POWER_ON_RESET_IN) q.parity_st <= 1'b1;
		end else begin
			q <= d;
		end
	end

	logic periph_pending;
	logic core_pending;
	always_comb begin
		core_pending = (q.interrupt_control[`BIT_TIMER_EN] & q.interrupt_control[`BIT_TIMER_FLAG])
			| (q.interrupt_control[`BIT_EXT_EN] & q.interrupt_control[`BIT_EXT_FLAG])
			| (q.interrupt_control[`BIT_PORT_EN] & q.interrupt_control[`BIT_PORT_FLAG]);
		if (GATED_VARIANT)
			periph_pending = q.interrupt_control[`BIT_BIT6_EN] & q.conv_en & q.conv_flag;
		else
			periph_pending = q.interrupt_control[`BIT_BIT6_EN] & q.conv_flag;
	end
	assign IRQ_REQ_OUT = q.interrupt_control[`BIT_GLOBAL_EN] & (core_pending | periph_pending);
	assign PC_OUT = q.pc;
	assign RDATA_OUT = q.rdata;

	AST_TIMER_FLAG_SET: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		TIMER_OVF_IN |=> q.interrupt_control[`BIT_TIMER_FLAG]) else $error("timer flag not set");
	AST_EXT_FLAG_SET: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		EXT_EDGE_IN |=> q.interrupt_control[`BIT_EXT_FLAG]) else $error("ext flag not set");
	AST_PORT_FLAG_SET: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		PORT_CHANGE_IN |=> q.interrupt_control[`BIT_PORT_FLAG]) else $error("port flag not set");
	AST_GLOBAL_BLOCK: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		!q.interrupt_control[`BIT_GLOBAL_EN] |-> !IRQ_REQ_OUT) else $error("irq with global off");
	AST_PCL_WRITE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		(WR_IN && ADDR_IN == `ADDR_PROGRAM_COUNTER_LOW) |=>
		PC_OUT == {$past(q.latch), $past(WDATA_IN)}) else $error("low write load");
	AST_JUMP_PAGE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		(JUMP_IN && !push && !RETURN_IN && !WR_IN) |=>
		PC_OUT[12:11] == $past(q.latch[4:3])) else $error("jump page bits");
	AST_CALL_RETURN: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		(CALL_IN && !IRQ_BRANCH_IN && !WR_IN) ##1 (RETURN_IN && !push && !WR_IN) |=>
		PC_OUT == $past(PC_OUT, 2) + 13'h1) else $error("return address");
	AST_PER_ENABLE_ZERO: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		$past(RD_IN && ADDR_IN == `ADDR_PERIPHERAL_IRQ_ENABLES) |->
		(RDATA_OUT & 8'hbf) == 8'h00) else $error("unused bits nonzero");
	AST_LATCH_KEPT: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		(push || pop) && !WR_IN |=> q.latch == $past(q.latch)) else $error("latch changed");
endmodule

//--- irq_source_model.sv
`timescale 1ns/100ps
module irq_source_model (
	input wire logic clk_in,
	input wire logic [3:0] fire_in,
	output logic [3:0] event_out
);
	// registered so each event follows the request one cycle later, for as many cycles as the request is held
	always_ff @(posedge clk_in) begin
		event_out <= fire_in;
	end
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic clk = 0, rst = 1, pwr = 1, bo = 0, par = 0, wr = 0, rd = 0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdat, d;
	logic [3:0] fire = 4'h0, ev;
	logic [4:0] ops = 5'h00;
	logic [10:0] tgt = 11'h000;
	logic [12:0] pc;
	logic irq;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	initial begin
		forever #12.5 clk = ~clk;
	end
	irq_source_model irq_source_model_inst (.clk_in(clk), .fire_in(fire), .event_out(ev));
	core_interrupt_pc_stack_ctrl core_interrupt_pc_stack_ctrl_inst (.CLK_SYS_IN(clk),
		.RST_IN(rst), .POWER_ON_RESET_IN(pwr), .BROWNOUT_RESET_IN(bo),
		.PARITY_RESET_IN(par), .PARITY_CFG_IN(1'b1), .ADDR_IN(addr), .WDATA_IN(wd),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .TIMER_OVF_IN(ev[0]),
		.EXT_EDGE_IN(ev[1]), .PORT_CHANGE_IN(ev[2]), .CONV_DONE_IN(ev[3]),
		.STEP_IN(ops[0]), .JUMP_IN(ops[1]), .CALL_IN(ops[2]), .IRQ_BRANCH_IN(ops[3]),
		.RETURN_IN(ops[4]), .TARGET_IN(tgt), .IRQ_VECTOR_IN(13'h0004), .PC_OUT(pc),
		.IRQ_REQ_OUT(irq));
	task automatic give_verdict();
		$display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(string what, logic [12:0] exp, logic [12:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wreg(logic [7:0] a, logic [7:0] v);
		@(posedge clk) {addr, wd, wr} <= {a, v, 1'b1};
		@(posedge clk) wr <= 0;
		#1;
	endtask
	task automatic rreg(logic [7:0] a);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 0;
		#1 d = rdat;
	endtask
	task automatic op(int i, logic [10:0] t);
		@(posedge clk) {ops, tgt} <= {5'h01 << i, t};
		@(posedge clk) ops <= 0;
		#1;
	endtask
	task automatic pulse(logic [3:0] m);
		@(posedge clk) fire <= m;
		@(posedge clk) fire <= 0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		{rst, pwr} <= 2'b00;
		rreg(8'h0b); chk("interrupt_control", 0, d);
		rreg(8'h33); chk("unmapped", 0, d);
		rreg(8'h8e); chk("cause", 8'h84, d & 8'hfe);
		wreg(8'h8e, 8'h07); rreg(8'h8e); chk("cause", 8'h87, d);
		pulse(4'h7); rreg(8'h0b); chk("interrupt_control", 8'h07, d);
		chk("irq", 0, irq);
		for (int i = 0; i < 3; i++) begin
			wreg(8'h0b, 8'h80 | (8'h20 >> i));
			pulse(4'h1 << i); rreg(8'h0b);
			chk("interrupt_control", 8'h80 | (8'h20 >> i) | (8'h04 >> i), d);
			chk("irq", 1, irq);
			wreg(8'h0b, (8'h20 >> i) | (8'h04 >> i)); chk("irq", 0, irq);
			wreg(8'h0b, 8'h80 | (8'h20 >> i)); chk("irq", 0, irq);
		end
		wreg(8'h0b, 8'h00); pulse(4'h8); rreg(8'h0c); chk("pflags", 8'h40, d);
		wreg(8'h8c, 8'hff); rreg(8'h8c); chk("penables", 8'h40, d);
		wreg(8'h0b, 8'h80); chk("irq", 0, irq);
		wreg(8'h0b, 8'hc0); chk("irq", 1, irq);
		wreg(8'h0c, 8'h00); chk("irq", 0, irq);
		wreg(8'h0a, 8'h1f); wreg(8'h02, 8'h34); chk("pc", 13'h1f34, pc);
		rreg(8'h02); chk("pcl", 8'h34, d);
		op(1, 11'h555); chk("pc", 13'h1d55, pc);
		wreg(8'h0a, 8'h07); op(1, 11'h00f); chk("pc", 13'h000f, pc);
		for (int i = 0; i < 9; i++) op(2, 11'h010 + 11'(i));
		for (int i = 0; i < 8; i++) begin
			op(4, 0); chk("pc", 13'h0018 - 13'(i), pc);
		end
		rreg(8'h0a); chk("latch", 8'h07, d);
		op(0, 0); chk("pc", 13'h0012, pc);
		op(3, 0); chk("pc", 13'h0004, pc);
		op(4, 0); chk("pc", 13'h0013, pc);
		// a call straight followed by a return must come back to the call site plus one
		@(posedge clk) {ops, tgt} <= {5'h04, 11'h020};
		@(posedge clk) ops <= 5'h10;
		@(posedge clk) ops <= 5'h00;
		#1 chk("pc", 13'h0014, pc);
		wreg(8'h0a, 8'h1f); wreg(8'h02, 8'h34);
		@(posedge clk) {rst, bo, par} <= 3'b111;
		repeat (2) @(posedge clk);
		{rst, bo, par} <= 3'b000;
		#1 chk("pc", 0, pc);
		rreg(8'h8e); chk("cause", 8'h82, d);
		give_verdict();
	end
endmodule
